// ===== core/dsa_pkg.sv
// Purpose: Shared constants and carriers for the data space access unit.
// Assumes: 16-bit byte addresses, 16-bit data words, one core clock.
// Notes:   All address map figures live here.
package dsa_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned NEAR_W    = 13;
  localparam int unsigned WORD_AW   = 15;
  localparam int unsigned WREG_N    = 16;
  localparam int unsigned WREG_AW   = 4;
  localparam int unsigned SFR_AW    = 10;

  // ************************************************************
  // Address map
  // ************************************************************
  localparam logic [ADDR_W-1:0] SFR_BASE     = 16'h0000;
  localparam logic [ADDR_W-1:0] SFR_LAST     = 16'h07FF;
  localparam logic [ADDR_W-1:0] NEAR_LAST    = 16'h1FFF;
  localparam logic [ADDR_W-1:0] RAM_BASE     = 16'h0800;
  localparam logic [ADDR_W-1:0] RAM_BYTES    = 16'h2400;
  localparam logic [ADDR_W-1:0] XY_BOUNDARY  = 16'h1C00;
  localparam logic [ADDR_W-1:0] WREG_LAST    = 16'h001F;
  localparam int unsigned       TOP_BIT      = 15;
  localparam int unsigned       RAM_WORDS    = 4608;
  localparam int unsigned       RAM_IDX_W    = 13;

  // ************************************************************
  // Steps and reset values
  // ************************************************************
  localparam logic [ADDR_W-1:0] STEP_BYTE    = 16'h0001;
  localparam logic [ADDR_W-1:0] STEP_WORD    = 16'h0002;
  localparam logic [DATA_W-1:0] ZERO_WORD    = 16'h0000;
  localparam logic [DATA_W-1:0] WREG_RST     = 16'h0000;
  localparam logic [DATA_W-1:0] STACK_RST    = 16'h0800;
  localparam logic [BYTE_W-1:0] ZERO_BYTE    = 8'h00;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    DSA_MODE_DIRECT,
    DSA_MODE_NEAR,
    DSA_MODE_INDIRECT,
    DSA_MODE_POSTINC
  } dsa_mode_t;

  typedef enum logic [1:0] {
    DSA_REGION_SFR,
    DSA_REGION_RAM,
    DSA_REGION_PSV,
    DSA_REGION_NONE
  } dsa_region_t;

  typedef struct packed {
    logic                 valid;
    logic                 byte_op;
    dsa_mode_t            mode;
    logic [WREG_AW-1:0]   pointer_sel;
    logic [ADDR_W-1:0]    direct_addr;
  } dsa_req_t;

  typedef struct packed {
    logic                 valid;
    logic                 byte_op;
    dsa_mode_t            mode;
    logic [WREG_AW-1:0]   pointer_sel;
    logic [ADDR_W-1:0]    direct_addr;
    logic [DATA_W-1:0]    data;
  } dsa_wreq_t;

endpackage

// ===== core/dsa_ram.sv
// Purpose: Byte-laned data RAM with two registered read ports.
// Assumes: One write port, two read ports, one clock.
// Notes:   Read data come out of a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module dsa_ram
  import dsa_pkg::*;
(
  input  wire logic                  mclk_i,
  input  wire logic [RAM_IDX_W-1:0]  wr_idx_i,
  input  wire logic [1:0]            wr_lane_i,
  input  wire logic [DATA_W-1:0]     wr_data_i,
  input  wire logic [RAM_IDX_W-1:0]  xrd_idx_i,
  input  wire logic [RAM_IDX_W-1:0]  yrd_idx_i,
  output logic      [DATA_W-1:0]     xrd_data_o,
  output logic      [DATA_W-1:0]     yrd_data_o
);

  logic [DATA_W-1:0] mem [RAM_WORDS];

  // ************************************************************
  // Storage
  // ************************************************************
  // One process owns the array; each lane has its own write strobe.
  always_ff @(posedge mclk_i)
  begin
    for (int g = 0; g < 2; g++)
    begin
      if (wr_lane_i[g])
      begin
        mem[wr_idx_i][g*BYTE_W +: BYTE_W] <= wr_data_i[g*BYTE_W +: BYTE_W];
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    xrd_data_o <= mem[xrd_idx_i];
    yrd_data_o <= mem[yrd_idx_i];
  end

endmodule
`default_nettype wire

// ===== core/dsa_access_unit.sv
// Purpose: Decodes data space accesses onto registers and RAM.
// Assumes: The core holds a request one cycle and waits one for read data.
// Notes:   Results appear one cycle after the request is taken.
// Notes on behaviour
// - Addresses are 16-bit byte addresses covering 64 Kbytes.
// - Top address bit set routes an X read to the visibility window.
// - Reads outside implemented memory return zero.
// - Even byte address is the low byte, odd is the high byte.
// - Post-increment adds one for byte operations, two for word operations.
// - Byte reads fetch the word, select by bit zero, return low.
// - Shared word decode with separate byte lane write strobes.
// - Word accesses at odd addresses raise an address error.
// - Misaligned read completes, misaligned write is dropped, trap follows.
// - Byte loads into a working register change only the byte picked by address bit zero.
// - Addresses 0x0000 to 0x07FF decode as register space.
// - Unused register space addresses read as zero.
// - Near addresses are reached by a 13-bit direct field.
// - Whole space reached by 16-bit direct or pointer indirect addressing.
// - Reads and writes use separate address generators.
// - X and Y generators have independent paths for dual reads.
// - X read bus serves all combined reads and the X prefetch.
// - Y read path is used only alongside X for dual operands.
// - Modulo on X and Y; bit reversal only on X writes.
// - Writes use the merged space; the boundary is fixed.
`timescale 1ns/1ps
`default_nettype none
module dsa_access_unit
  import dsa_pkg::*;
#(
  parameter logic [ADDR_W-1:0] XY_SPLIT  = XY_BOUNDARY,
  parameter logic [ADDR_W-1:0] RAM_SIZE  = RAM_BYTES
)
(
  input  wire logic                mclk_i,
  input  wire logic                rst_b_i,
  input  wire dsa_req_t            xrd_req_i,
  input  wire dsa_req_t            yrd_req_i,
  input  wire dsa_wreq_t           wr_req_i,
  input  wire logic                mod_x_i,
  input  wire logic                mod_y_i,
  input  wire logic                brev_x_i,
  input  wire logic [ADDR_W-1:0]   mod_x_end_i,
  input  wire logic [ADDR_W-1:0]   mod_x_start_i,
  input  wire logic [ADDR_W-1:0]   mod_y_end_i,
  input  wire logic [ADDR_W-1:0]   mod_y_start_i,
  input  wire logic [ADDR_W-1:0]   psv_rd_data_i,
  output logic      [ADDR_W-1:0]   psv_addr_o,
  output logic                     psv_rd_o,
  output logic      [DATA_W-1:0]   xrd_data_o,
  output logic                     xrd_valid_o,
  output logic      [DATA_W-1:0]   yrd_data_o,
  output logic                     yrd_valid_o,
  output logic      [DATA_W-1:0]   wreg_data_o [WREG_N],
  output logic                     addr_err_o
);

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic dsa_region_t region_of(input logic [ADDR_W-1:0] a);
    dsa_region_t r;
    r = DSA_REGION_NONE;
    if (a[TOP_BIT])
      r = DSA_REGION_PSV;
    else if (a <= SFR_LAST)
      r = DSA_REGION_SFR;
    else if (a < RAM_BASE + RAM_SIZE)
      r = DSA_REGION_RAM;
    return r;
  endfunction

  function automatic logic [RAM_IDX_W-1:0] ram_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - RAM_BASE;
    return off[RAM_IDX_W:1];
  endfunction

  function automatic logic [ADDR_W-1:0] gen_ea(input dsa_mode_t m,
                                               input logic [ADDR_W-1:0] d,
                                               input logic [DATA_W-1:0] p);
    logic [ADDR_W-1:0] ea;
    ea = p;
    if (m == DSA_MODE_DIRECT)
      ea = d;
    else if (m == DSA_MODE_NEAR)
      ea = {{(ADDR_W-NEAR_W){1'b0}}, d[NEAR_W-1:0]};
    return ea;
  endfunction

  function automatic logic [ADDR_W-1:0] post_step(input logic [ADDR_W-1:0] ea,
                                                  input logic byte_op,
                                                  input logic mod_en,
                                                  input logic [ADDR_W-1:0] ms,
                                                  input logic [ADDR_W-1:0] me);
    logic [ADDR_W-1:0] n;
    n = ea + (byte_op ? STEP_BYTE : STEP_WORD);
    if (mod_en && (ea >= me))
      n = ms;
    return n;
  endfunction

  function automatic logic [ADDR_W-1:0] bit_rev(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] r;
    r = a;
    for (int i = 1; i < ADDR_W; i++)
      r[i] = a[ADDR_W-i];
    return r;
  endfunction

  // ************************************************************
  // Working registers
  // ************************************************************
  logic [DATA_W-1:0] wreg_ff [WREG_N];
  logic [DATA_W-1:0] xptr;
  logic [DATA_W-1:0] yptr;
  logic [DATA_W-1:0] wptr;

  assign xptr = wreg_ff[xrd_req_i.pointer_sel];
  assign yptr = wreg_ff[yrd_req_i.pointer_sel];
  assign wptr = wreg_ff[wr_req_i.pointer_sel];

  // ************************************************************
  // Address generation, one unit per path
  // ************************************************************
  logic [ADDR_W-1:0] x_ea;
  logic [ADDR_W-1:0] y_ea;
  logic [ADDR_W-1:0] w_ea;
  logic              y_use;

  assign x_ea  = gen_ea(xrd_req_i.mode, xrd_req_i.direct_addr, xptr);
  assign y_ea  = gen_ea(yrd_req_i.mode, yrd_req_i.direct_addr, yptr);
  assign y_use = yrd_req_i.valid && xrd_req_i.valid && !yrd_req_i.byte_op;
  assign w_ea  = (brev_x_i && wr_req_i.mode == DSA_MODE_POSTINC &&
                  wr_req_i.direct_addr < XY_SPLIT) ?
                 bit_rev(gen_ea(wr_req_i.mode, wr_req_i.direct_addr, wptr)) :
                 gen_ea(wr_req_i.mode, wr_req_i.direct_addr, wptr);

  // ************************************************************
  // Alignment checks
  // ************************************************************
  logic x_mis;
  logic y_mis;
  logic w_mis;

  assign x_mis = xrd_req_i.valid && !xrd_req_i.byte_op && x_ea[0];
  assign y_mis = y_use && y_ea[0];
  assign w_mis = wr_req_i.valid && !wr_req_i.byte_op && w_ea[0];

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      addr_err_o <= 1'b0;
    else
      addr_err_o <= x_mis || y_mis || w_mis;
  end

  // ************************************************************
  // Write lanes
  // ************************************************************
  logic [1:0]        w_lane;
  logic [DATA_W-1:0] w_data;
  dsa_region_t       w_reg;

  assign w_reg  = region_of(w_ea);
  assign w_lane = !wr_req_i.valid || w_mis ? 2'h0 :
                  !wr_req_i.byte_op ? 2'h3 :
                  (w_ea[0] ? 2'h2 : 2'h1);
  assign w_data = wr_req_i.byte_op ?
                  {wr_req_i.data[BYTE_W-1:0], wr_req_i.data[BYTE_W-1:0]} :
                  wr_req_i.data;

  // ************************************************************
  // RAM
  // ************************************************************
  logic [DATA_W-1:0] ram_x;
  logic [DATA_W-1:0] ram_y;

  dsa_ram u_ram (
    .mclk_i     (mclk_i),
    .wr_idx_i   (ram_idx(w_ea)),
    .wr_lane_i  (w_reg == DSA_REGION_RAM ? w_lane : 2'h0),
    .wr_data_i  (w_data),
    .xrd_idx_i  (ram_idx(x_ea)),
    .yrd_idx_i  (ram_idx(y_ea)),
    .xrd_data_o (ram_x),
    .yrd_data_o (ram_y)
  );

  // ************************************************************
  // Pointer and register updates
  // ************************************************************
  for (genvar g = 0; g < WREG_N; g++)
  begin : g_wreg
    logic          hit_w;
    logic          hit_px;
    logic          hit_py;
    logic          hit_pw;
    logic [DATA_W-1:0] nxt_wreg;
    assign hit_w  = (w_reg == DSA_REGION_SFR) && (w_ea <= WREG_LAST) &&
                    (w_ea[WREG_AW:1] == WREG_AW'(g));
    assign hit_px = xrd_req_i.valid && xrd_req_i.mode == DSA_MODE_POSTINC &&
                    xrd_req_i.pointer_sel == WREG_AW'(g);
    assign hit_py = y_use && yrd_req_i.mode == DSA_MODE_POSTINC &&
                    yrd_req_i.pointer_sel == WREG_AW'(g);
    assign hit_pw = wr_req_i.valid && wr_req_i.mode == DSA_MODE_POSTINC &&
                    wr_req_i.pointer_sel == WREG_AW'(g);
    always_comb
    begin
      nxt_wreg = wreg_ff[g];
      if (hit_px)
        nxt_wreg = post_step(x_ea, xrd_req_i.byte_op, mod_x_i,
                             mod_x_start_i, mod_x_end_i);
      if (hit_py)
        nxt_wreg = post_step(y_ea, yrd_req_i.byte_op, mod_y_i,
                             mod_y_start_i, mod_y_end_i);
      if (hit_pw)
        nxt_wreg = post_step(w_ea, wr_req_i.byte_op, mod_x_i,
                             mod_x_start_i, mod_x_end_i);
      if (hit_w && w_lane[0])
        nxt_wreg[BYTE_W-1:0] = w_data[BYTE_W-1:0];
      if (hit_w && w_lane[1])
        nxt_wreg[DATA_W-1:BYTE_W] = w_data[DATA_W-1:BYTE_W];
    end
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
        wreg_ff[g] <= (g == WREG_N-1) ? STACK_RST : WREG_RST;
      else
        wreg_ff[g] <= nxt_wreg;
    end
    assign wreg_data_o[g] = wreg_ff[g];
  end

  // ************************************************************
  // Read pipeline
  // ************************************************************
  dsa_region_t       x_reg_ff;
  dsa_region_t       y_reg_ff;
  logic              x_byte_ff;
  logic              x_odd_ff;
  logic              y_val_ff;
  logic [DATA_W-1:0] x_sfr_ff;
  logic [DATA_W-1:0] y_sfr_ff;

  function automatic logic [DATA_W-1:0] sfr_word(input logic [ADDR_W-1:0] a,
                                                 input logic [DATA_W-1:0] w);
    return (a <= WREG_LAST) ? w : ZERO_WORD;
  endfunction

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      x_reg_ff    <= DSA_REGION_NONE;
      y_reg_ff    <= DSA_REGION_NONE;
      x_byte_ff   <= 1'b0;
      x_odd_ff    <= 1'b0;
      xrd_valid_o <= 1'b0;
      y_val_ff    <= 1'b0;
      x_sfr_ff    <= ZERO_WORD;
      y_sfr_ff    <= ZERO_WORD;
    end
    else
    begin
      x_reg_ff    <= region_of(x_ea);
      y_reg_ff    <= region_of(y_ea);
      x_byte_ff   <= xrd_req_i.byte_op;
      x_odd_ff    <= x_ea[0];
      xrd_valid_o <= xrd_req_i.valid;
      y_val_ff    <= y_use;
      x_sfr_ff    <= sfr_word(x_ea, wreg_ff[x_ea[WREG_AW:1]]);
      y_sfr_ff    <= sfr_word(y_ea, wreg_ff[y_ea[WREG_AW:1]]);
    end
  end

  assign psv_addr_o = x_ea;
  assign psv_rd_o   = xrd_req_i.valid && region_of(x_ea) == DSA_REGION_PSV;

  logic [DATA_W-1:0] x_word;

  always_comb
  begin
    case (x_reg_ff)
      DSA_REGION_SFR: x_word = x_sfr_ff;
      DSA_REGION_RAM: x_word = ram_x;
      DSA_REGION_PSV: x_word = psv_rd_data_i;
      default:        x_word = ZERO_WORD;
    endcase
  end

  assign xrd_data_o = !xrd_valid_o ? ZERO_WORD :
                      !x_byte_ff ? x_word :
                      {ZERO_BYTE, x_odd_ff ? x_word[DATA_W-1:BYTE_W]
                                           : x_word[BYTE_W-1:0]};

  always_comb
  begin
    yrd_data_o = ZERO_WORD;
    case (y_reg_ff)
      DSA_REGION_SFR: yrd_data_o = y_sfr_ff;
      DSA_REGION_RAM: yrd_data_o = ram_y;
      default:        yrd_data_o = ZERO_WORD;
    endcase
    if (!y_val_ff)
      yrd_data_o = ZERO_WORD;
  end

  assign yrd_valid_o = y_val_ff;

endmodule
`default_nettype wire

// ===== tb/dsa_access_assertions.sv
// Purpose: Port assertions for the data space access unit.
// Assumes: Requests are taken on the rising clock edge.
// Notes:   Bound to every access unit instance.
`timescale 1ns/1ps
`default_nettype none
module dsa_access_chk
  import dsa_pkg::*;
#(
  parameter logic [ADDR_W-1:0] XY_SPLIT = XY_BOUNDARY,
  parameter logic [ADDR_W-1:0] RAM_SIZE = RAM_BYTES
)
(
  input wire logic              mclk_i,
  input wire logic              rst_b_i,
  input wire dsa_req_t          xrd_req_i,
  input wire dsa_req_t          yrd_req_i,
  input wire dsa_wreq_t         wr_req_i,
  input wire logic              mod_x_i,
  input wire logic              mod_y_i,
  input wire logic              brev_x_i,
  input wire logic [ADDR_W-1:0] mod_x_end_i,
  input wire logic [ADDR_W-1:0] mod_x_start_i,
  input wire logic [ADDR_W-1:0] mod_y_end_i,
  input wire logic [ADDR_W-1:0] mod_y_start_i,
  input wire logic [ADDR_W-1:0] psv_rd_data_i,
  input wire logic [ADDR_W-1:0] psv_addr_o,
  input wire logic              psv_rd_o,
  input wire logic [DATA_W-1:0] xrd_data_o,
  input wire logic              xrd_valid_o,
  input wire logic [DATA_W-1:0] yrd_data_o,
  input wire logic              yrd_valid_o,
  input wire logic [DATA_W-1:0] wreg_data_o [WREG_N],
  input wire logic              addr_err_o
);
  // ****
  // Helpers
  // ****
  logic [ADDR_W-1:0] ea_x;
  logic [ADDR_W-1:0] ea_w;
  logic [ADDR_W-1:0] ea_y;
  logic [ADDR_W-1:0] ptr_nxt;
  logic [DATA_W-1:0] wr_cur;
  logic [DATA_W-1:0] lane_val;
  logic              odd_word;
  logic              zero_x;
  logic              byte_wreg;

  function automatic logic [ADDR_W-1:0] ea_of(input dsa_mode_t m, input logic [ADDR_W-1:0] d,
                                               input logic [DATA_W-1:0] w);
    if (m == DSA_MODE_DIRECT)
      return d;
    if (m == DSA_MODE_NEAR)
      return {3'h0, d[NEAR_W-1:0]};
    return w;
  endfunction

  assign ea_x      = ea_of(xrd_req_i.mode, xrd_req_i.direct_addr,
                           wreg_data_o[xrd_req_i.pointer_sel]);
  assign ea_w      = ea_of(wr_req_i.mode, wr_req_i.direct_addr,
                           wreg_data_o[wr_req_i.pointer_sel]);
  assign ea_y      = ea_of(yrd_req_i.mode, yrd_req_i.direct_addr,
                           wreg_data_o[yrd_req_i.pointer_sel]);
  assign odd_word  = (xrd_req_i.valid && !xrd_req_i.byte_op && ea_x[0])
                  || (xrd_req_i.valid && yrd_req_i.valid && !yrd_req_i.byte_op && ea_y[0])
                  || (wr_req_i.valid && !wr_req_i.byte_op && ea_w[0]);
  assign zero_x    = !ea_x[TOP_BIT] && ((ea_x > WREG_LAST && ea_x < RAM_BASE)
                  || ea_x >= RAM_BASE + RAM_SIZE);
  assign ptr_nxt   = ea_x + (xrd_req_i.byte_op ? STEP_BYTE : STEP_WORD);
  assign byte_wreg = wr_req_i.valid && wr_req_i.byte_op && wr_req_i.mode == DSA_MODE_DIRECT
                  && wr_req_i.direct_addr <= WREG_LAST && !xrd_req_i.valid && !yrd_req_i.valid;
  assign wr_cur    = wreg_data_o[wr_req_i.direct_addr[4:1]];
  assign lane_val  = wr_req_i.direct_addr[0] ? {wr_req_i.data[7:0], wr_cur[7:0]}
                                             : {wr_cur[15:8], wr_req_i.data[7:0]};
  // ****
  // Properties
  // ****
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_odd_word_trap: assert property (odd_word |=> addr_err_o)
    else $error("odd word access without address error");
  a_trap_cause: assert property (addr_err_o |-> $past(odd_word))
    else $error("address error without misaligned access");
  a_x_answer: assert property (xrd_req_i.valid |=> xrd_valid_o)
    else $error("X read not answered next cycle");
  a_y_paired: assert property (yrd_valid_o |-> $past(xrd_req_i.valid && yrd_req_i.valid
    && !yrd_req_i.byte_op))
    else $error("Y read answered without a paired X word read");
  a_dual_fetch: assert property (xrd_req_i.valid && yrd_req_i.valid && !yrd_req_i.byte_op
    ##1 1'b1 |-> xrd_valid_o && yrd_valid_o)
    else $error("dual read not answered on both paths");
  a_psv_route: assert property (xrd_req_i.valid |-> psv_rd_o == ea_x[TOP_BIT]
    && (!psv_rd_o || psv_addr_o == ea_x))
    else $error("visibility window routing wrong");
  a_unimpl_zero: assert property (xrd_req_i.valid && zero_x |=> xrd_data_o == ZERO_WORD)
    else $error("unimplemented address read not zero");
  a_byte_low_lane: assert property (xrd_req_i.valid && xrd_req_i.byte_op
    |=> xrd_data_o[15:8] == ZERO_BYTE)
    else $error("byte read upper byte not zero");
  a_postinc_step: assert property (xrd_req_i.valid && xrd_req_i.mode == DSA_MODE_POSTINC
    && !mod_x_i && !wr_req_i.valid && !yrd_req_i.valid
    |=> wreg_data_o[$past(xrd_req_i.pointer_sel)] == $past(ptr_nxt))
    else $error("post increment step wrong");
  a_byte_lane_wr: assert property (byte_wreg
    |=> wreg_data_o[$past(wr_req_i.direct_addr[4:1])] == $past(lane_val))
    else $error("byte write touched the wrong lane");

  c_trap: cover property (addr_err_o);
  c_dual: cover property (yrd_valid_o);
  c_psv: cover property (psv_rd_o ##1 xrd_valid_o);
endmodule

bind dsa_access_unit dsa_access_chk #(.XY_SPLIT(XY_SPLIT), .RAM_SIZE(RAM_SIZE)) u_chk (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .xrd_req_i(xrd_req_i), .yrd_req_i(yrd_req_i),
  .wr_req_i(wr_req_i), .mod_x_i(mod_x_i), .mod_y_i(mod_y_i), .brev_x_i(brev_x_i),
  .mod_x_end_i(mod_x_end_i), .mod_x_start_i(mod_x_start_i), .mod_y_end_i(mod_y_end_i),
  .mod_y_start_i(mod_y_start_i), .psv_rd_data_i(psv_rd_data_i), .psv_addr_o(psv_addr_o),
  .psv_rd_o(psv_rd_o), .xrd_data_o(xrd_data_o), .xrd_valid_o(xrd_valid_o),
  .yrd_data_o(yrd_data_o), .yrd_valid_o(yrd_valid_o), .wreg_data_o(wreg_data_o),
  .addr_err_o(addr_err_o));
`default_nettype wire

// ===== tb/dsa_psv_model.sv
// Purpose: Program space visibility read model behind the access unit.
// Assumes: The read word is due one cycle after the read strobe.
// Notes:   Between reads the data toggles so stale data never matches.
`timescale 1ns/1ps
`default_nettype none
module dsa_psv_model
  import dsa_pkg::*;
#(
  parameter logic [DATA_W-1:0] PSV_KEY = 16'h5A5A
)
(
  input  wire logic              mclk_i,
  input  wire logic              psv_rd_i,
  input  wire logic [ADDR_W-1:0] psv_addr_i,
  output logic      [DATA_W-1:0] psv_data_o
);
  // ****
  // Read port
  // ****
  logic [DATA_W-1:0] data_ff = ZERO_WORD;

  always @(posedge mclk_i)
  begin
    if (psv_rd_i)
      data_ff <= psv_addr_i ^ PSV_KEY;
    else
      data_ff <= ~data_ff;
  end
  assign psv_data_o = data_ff;
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the data space access unit.
// Assumes: Inputs change on the falling edge, results are read one cycle later.
// Notes:   Table rows hold plain accesses, hand tests the awkward cases.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dsa_pkg::*;
;
  // ****
  // Signals
  // ****
  localparam logic [DATA_W-1:0] PSV_KEY = 16'h5A5A;
  localparam dsa_req_t          NOQ     = '0;
  localparam dsa_wreq_t         NOW     = '0;
  localparam dsa_mode_t         MD      = DSA_MODE_DIRECT;
  localparam dsa_mode_t         MP      = DSA_MODE_POSTINC;
  // Flags are write, byte, compare data and expect address error.
  typedef struct packed {
    logic [3:0]        flags;
    dsa_mode_t         mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dsa_row_t;
  localparam dsa_row_t ROWS [19] = '{
    '{4'h8, MD, 16'h0800, 16'hA55A}, '{4'h2, MD, 16'h0800, 16'hA55A},
    '{4'h6, MD, 16'h0800, 16'h005A}, '{4'h6, MD, 16'h0801, 16'h00A5},
    '{4'hC, MD, 16'h0801, 16'h0033}, '{4'h2, MD, 16'h0800, 16'h335A},
    '{4'h8, MD, 16'h0802, 16'h1234}, '{4'h9, MD, 16'h0803, 16'hFFFF},
    '{4'h2, MD, 16'h0802, 16'h1234}, '{4'h1, MD, 16'h0801, 16'h0000},
    '{4'h2, MD, 16'h0100, 16'h0000}, '{4'h2, MD, 16'h3000, 16'h0000},
    '{4'h8, MD, 16'h2BFE, 16'h0F0F}, '{4'h2, MD, 16'h2BFE, 16'h0F0F},
    '{4'h8, MD, 16'h0004, 16'h1122}, '{4'hC, MD, 16'h0004, 16'h0077},
    '{4'h2, MD, 16'h0004, 16'h1177}, '{4'h2, DSA_MODE_NEAR, 16'hE800, 16'h335A},
    '{4'h2, MD, 16'h7FFE, 16'h0000}};
  logic              mclk_i;
  logic              rst_b_i;
  dsa_req_t          xq = '0;
  dsa_req_t          yq = '0;
  dsa_wreq_t         wq = '0;
  logic              mod_x = 1'b0;
  logic              brev = 1'b0;
  logic [ADDR_W-1:0] mx_start = 16'h0800;
  logic [ADDR_W-1:0] mx_end = 16'h0806;
  logic [DATA_W-1:0] psv_data;
  logic [ADDR_W-1:0] psv_addr;
  logic              psv_rd;
  logic [DATA_W-1:0] xrd_data;
  logic              xrd_valid;
  logic [DATA_W-1:0] yrd_data;
  logic              yrd_valid;
  logic [DATA_W-1:0] wreg [WREG_N];
  logic              addr_err;
  int                fail_count = 0;
  int                num_checks = 0;

  dsa_access_unit DUT (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .xrd_req_i(xq), .yrd_req_i(yq), .wr_req_i(wq),
    .mod_x_i(mod_x), .mod_y_i(mod_x), .brev_x_i(brev), .mod_x_end_i(mx_end),
    .mod_x_start_i(mx_start), .mod_y_end_i(mx_end), .mod_y_start_i(mx_start),
    .psv_rd_data_i(psv_data), .psv_addr_o(psv_addr), .psv_rd_o(psv_rd),
    .xrd_data_o(xrd_data), .xrd_valid_o(xrd_valid), .yrd_data_o(yrd_data),
    .yrd_valid_o(yrd_valid), .wreg_data_o(wreg), .addr_err_o(addr_err));

  dsa_psv_model #(.PSV_KEY(PSV_KEY)) u_psv (
    .mclk_i(mclk_i), .psv_rd_i(psv_rd), .psv_addr_i(psv_addr), .psv_data_o(psv_data));
  // ****
  // Tasks
  // ****
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input dsa_req_t x, input dsa_req_t y, input dsa_wreq_t w);
    xq = x;
    yq = y;
    wq = w;
    @(negedge mclk_i);
  endtask

  function automatic dsa_req_t xr(input logic b, input dsa_mode_t m,
                                  input logic [WREG_AW-1:0] p, input logic [ADDR_W-1:0] a);
    return '{1'b1, b, m, p, a};
  endfunction

  function automatic dsa_wreq_t ww(input logic b, input logic [ADDR_W-1:0] a,
                                   input logic [DATA_W-1:0] d);
    return '{1'b1, b, MD, 4'h0, a, d};
  endfunction

  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  initial
  begin
    #5000;
    fail_count++;
    stop_test();
  end

  initial
  begin
    rst_b_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    rst_b_i = 1'b1;
    check(wreg[15], STACK_RST);
    check(wreg[0], WREG_RST);
    check(xrd_valid, 1'b0);
    foreach (ROWS[i])
    begin
      if (ROWS[i].flags[3])
        cyc(NOQ, NOQ, ww(ROWS[i].flags[2], ROWS[i].addr, ROWS[i].data));
      else
        cyc(xr(ROWS[i].flags[2], ROWS[i].mode, 4'h0, ROWS[i].addr), NOQ, NOW);
      check(xrd_valid, !ROWS[i].flags[3]);
      check(addr_err, ROWS[i].flags[0]);
      if (ROWS[i].flags[1])
        check(xrd_data, ROWS[i].data);
    end
    cyc(xr(1'b0, MD, 4'h0, 16'h0800), NOQ, ww(1'b0, 16'h0806, 16'hBEEF));
    check(xrd_data, 16'h335A);
    cyc(xr(1'b0, MD, 4'h0, 16'h0806), xr(1'b0, MD, 4'h0, 16'h2BFE), ww(1'b0, 16'h0006, 16'h0800));
    check(yrd_valid, 1'b1);
    check(yrd_data, 16'h0F0F);
    check(xrd_data, 16'hBEEF);
    cyc(NOQ, xr(1'b0, MD, 4'h0, 16'h2BFE), NOW);
    check(yrd_valid, 1'b0);
    cyc(xr(1'b0, MD, 4'h0, 16'h0800), xr(1'b1, MD, 4'h0, 16'h2BFE), NOW);
    check(yrd_valid, 1'b0);
    cyc(xr(1'b0, MP, 4'h3, 16'h0000), NOQ, NOW);
    check(xrd_data, 16'h335A);
    check(wreg[3], 16'h0802);
    cyc(xr(1'b1, MP, 4'h3, 16'h0000), NOQ, NOW);
    check(xrd_data, 16'h0034);
    check(wreg[3], 16'h0803);
    cyc(xr(1'b0, DSA_MODE_INDIRECT, 4'h3, 16'h0000), NOQ, NOW);
    check(addr_err, 1'b1);
    check(wreg[3], 16'h0803);
    mod_x = 1'b1;
    cyc(NOQ, NOQ, ww(1'b0, 16'h0006, 16'h0806));
    cyc(xr(1'b0, MP, 4'h3, 16'h0000), NOQ, NOW);
    check(xrd_data, 16'hBEEF);
    check(wreg[3], 16'h0800);
    cyc(NOQ, NOQ, ww(1'b0, 16'h0006, 16'h0806));
    cyc(xr(1'b0, MD, 4'h0, 16'h0800), xr(1'b0, MP, 4'h3, 16'h0000), NOW);
    check(yrd_data, 16'hBEEF);
    check(wreg[3], 16'h0800);
    mod_x = 1'b0;
    cyc(NOQ, NOQ, ww(1'b0, 16'h0006, 16'h4000));
    brev = 1'b1;
    cyc(NOQ, NOQ, '{1'b1, 1'b0, MP, 4'h3, 16'h0000, 16'h00BB});
    check(wreg[2], 16'h00BB);
    brev = 1'b0;
    cyc(xr(1'b0, MD, 4'h0, 16'h8010), NOQ, NOW);
    check(psv_addr, 16'h8010);
    check(psv_rd, 1'b1);
    check(xrd_data, 16'h8010 ^ PSV_KEY);
    rst_b_i = 1'b0;
    #1;
    check(wreg[3], WREG_RST);
    check(wreg[15], STACK_RST);
    check(addr_err, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
